/* design/esac_top.sv */
/*
 * Extender status, alert and control logic: startup sequencing, ready and link-up
 * indicators, alert mirroring and control line forwarding.
 * Assumes pins arrive asynchronous (three-flop filter) and link-side signals are on clk_in.
 */
`timescale 1ns/1ns

module esac_sync3 (
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic lvl_nxt;

   assign lvl_nxt   = (s2_r == s3_r) ? s3_r : lvl_r;
   assign level_out = lvl_r;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         lvl_r <= 1'b0;
      end else begin
         s1_r  <= pin_in;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end
endmodule

module esac_top #(
   parameter int REMOTE_RESET_CYC = esac_pkg::REMOTE_RESET_CYC
) (
   input  wire logic                             clk_in,
   input  wire logic                             sys_rst_in,
   input  wire logic                             power_on_in,
   input  wire logic                             far_side_sel_in,
   input  wire logic                             scl_in,
   input  wire logic                             sda_in,
   input  wire logic                             rate_select_1_in,
   input  wire logic                             rate_select_2_in,
   input  wire logic [1:0]                       peer_rate_in,
   input  wire logic                             link_alive_in,
   input  wire logic                             cable_ok_in,
   input  wire logic                             buffer_full_in,
   input  wire logic [esac_pkg::EVENT_W-1:0]     event_in,
   input  wire logic [esac_pkg::EVENT_W-1:0]     notify_en_in,
   input  wire logic                             irq_line_mode_in,
   input  wire logic                             ara_lowest_in,
   input  wire logic                             alert_pin_in,
   input  wire logic                             remote_alert_n_in,
   input  wire logic                             ctrl_pin_in,
   input  wire logic                             ctrl_src_sel_in,
   input  wire logic                             aux_software_value_in,
   input  wire logic                             remote_ctrl_in,
   output logic                                  functional_out,
   output logic                                  transceiver_lp_out,
   output logic                                  rdy_o_out,
   output logic                                  rdy_oe_out,
   output logic                                  link_o_out,
   output logic                                  link_oe_out,
   output logic                                  local_ctl_only_out,
   output logic                                  alert_o_out,
   output logic                                  alert_oe_out,
   output logic                                  alert_sample_out,
   output logic                                  ctrl_fwd_out,
   output logic                                  ctrl_fwd_valid_out,
   output logic                                  ctrl_o_out,
   output logic                                  ctrl_oe_out,
   output logic                                  remote_reset_out
);

   // ---------------------------------------------------------------
   // Pin filters
   // ---------------------------------------------------------------
   logic on_f;
   logic remote_f;
   logic scl_f;
   logic sda_f;
   logic rs1_f;
   logic rs2_f;
   logic alert_f;
   logic ctrl_f;

   esac_sync3 u_on  (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(power_on_in),      .level_out(on_f));
   esac_sync3 u_rem (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(far_side_sel_in),  .level_out(remote_f));
   esac_sync3 u_scl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(scl_in),           .level_out(scl_f));
   esac_sync3 u_sda (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(sda_in),           .level_out(sda_f));
   esac_sync3 u_rs1 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(rate_select_1_in), .level_out(rs1_f));
   esac_sync3 u_rs2 (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(rate_select_2_in), .level_out(rs2_f));
   esac_sync3 u_alt (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(alert_pin_in),     .level_out(alert_f));
   esac_sync3 u_ctl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(ctrl_pin_in),      .level_out(ctrl_f));

   // ---------------------------------------------------------------
   // Startup sequencer
   // ---------------------------------------------------------------
   esac_pkg::esac_state_t        state_r;
   esac_pkg::esac_state_t        state_nxt;
   logic [esac_pkg::CNT_W-1:0]   seq_cnt_r;
   logic                         hold_rst;
   logic                         run;
   logic                         local_mode;
   logic                         tri_done;
   logic                         init_done;

   assign hold_rst   = sys_rst_in | ~on_f;
   assign run        = (state_r == esac_pkg::ESAC_RUN);
   assign local_mode = ~remote_f;
   assign tri_done   = (seq_cnt_r == 12'(esac_pkg::STARTUP_TRI_CYC - 1));
   assign init_done  = (seq_cnt_r == 12'(esac_pkg::STARTUP_INIT_CYC - 1));

   always_comb begin
      case (state_r)
         esac_pkg::ESAC_OFF:  state_nxt = esac_pkg::ESAC_TRI;
         esac_pkg::ESAC_TRI:  state_nxt = tri_done ? esac_pkg::ESAC_INIT : esac_pkg::ESAC_TRI;
         esac_pkg::ESAC_INIT: state_nxt = init_done ? esac_pkg::ESAC_RUN : esac_pkg::ESAC_INIT;
         esac_pkg::ESAC_RUN:  state_nxt = esac_pkg::ESAC_RUN;
         default:             state_nxt = esac_pkg::ESAC_OFF;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         state_r   <= esac_pkg::ESAC_OFF;
         seq_cnt_r <= esac_pkg::CNT_ZERO;
      end else begin
         state_r   <= state_nxt;
         seq_cnt_r <= (state_nxt != state_r) ? esac_pkg::CNT_ZERO : seq_cnt_r + 12'h001;
      end
   end

   assign functional_out     = run;
   assign transceiver_lp_out = (state_r == esac_pkg::ESAC_OFF);

   // ---------------------------------------------------------------
   // Bus idle detection and ready indicator
   // ---------------------------------------------------------------
   logic                         sda_d_r;
   logic [esac_pkg::CNT_W-1:0]   idle_cnt_r;
   logic                         ready_r;
   logic                         stop_seen;
   logic                         idle_seen;

   assign stop_seen = scl_f & sda_f & ~sda_d_r;
   assign idle_seen = (idle_cnt_r == 12'(esac_pkg::READY_IDLE_CYC - 1)) & scl_f;

   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         sda_d_r    <= 1'b1;
         idle_cnt_r <= esac_pkg::CNT_ZERO;
         ready_r    <= 1'b0;
      end else begin
         sda_d_r    <= sda_f;
         idle_cnt_r <= (scl_f && !idle_seen) ? idle_cnt_r + 12'h001 : (scl_f ? idle_cnt_r : esac_pkg::CNT_ZERO);
         if (run && local_mode && (stop_seen || idle_seen)) begin
            ready_r <= 1'b1;
         end
      end
   end

   assign rdy_o_out          = 1'b0;
   assign rdy_oe_out         = ready_r & run & local_mode & ~buffer_full_in;

   // ---------------------------------------------------------------
   // Link status
   // ---------------------------------------------------------------
   logic link_ok;
   logic link_up_r;
   logic if_ready;

   assign link_ok  = link_alive_in & cable_ok_in & (peer_rate_in == {rs2_f, rs1_f});
   assign if_ready = local_mode ? ready_r : 1'b1;

   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         link_up_r <= 1'b0;
      end else begin
         link_up_r <= run & link_ok & if_ready;
      end
   end

   assign link_o_out         = 1'b0;
   assign link_oe_out        = link_up_r;
   assign local_ctl_only_out = rdy_oe_out & ~link_up_r;

   // ---------------------------------------------------------------
   // Alert and interrupt
   // ---------------------------------------------------------------
   logic                         irq_any;
   logic                         ara_rel_r;
   logic                         int_alert_n;
   logic                         mirror_n;
   logic [esac_pkg::CNT_W-1:0]   smp_cnt_r;
   logic                         smp_tick;
   logic                         alert_smp_r;

   assign irq_any     = |(event_in & notify_en_in);
   assign int_alert_n = ~(irq_any & ~ara_rel_r);
   assign mirror_n    = link_up_r ? remote_alert_n_in : 1'b1;
   assign smp_tick    = (smp_cnt_r == 12'(esac_pkg::ALERT_SAMPLE_CYC - 1));

   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         ara_rel_r   <= 1'b0;
         smp_cnt_r   <= esac_pkg::CNT_ZERO;
         alert_smp_r <= 1'b1;
      end else begin
         if (!irq_any) begin
            ara_rel_r <= 1'b0;
         end else if (ara_lowest_in && !irq_line_mode_in) begin
            ara_rel_r <= 1'b1;
         end
         smp_cnt_r <= smp_tick ? esac_pkg::CNT_ZERO : smp_cnt_r + 12'h001;
         if (smp_tick && remote_f) begin
            alert_smp_r <= alert_f;
         end
      end
   end

   assign alert_o_out      = 1'b0;
   assign alert_oe_out     = run & local_mode & ~(mirror_n & int_alert_n);
   assign alert_sample_out = alert_smp_r;

   // ---------------------------------------------------------------
   // Remote reset and control line
   // ---------------------------------------------------------------
   logic [esac_pkg::RR_CNT_W-1:0] rr_cnt_r;
   logic                          rr_cond;
   logic                          rr_hit;
   logic                          ctrl_oe_r;
   logic                          ctrl_fwd_r;
   logic                          ctrl_o_r;
   logic                          ctrl_sel_val;

   assign ctrl_sel_val = ctrl_src_sel_in ? aux_software_value_in : remote_ctrl_in;

   assign rr_cond = local_mode ? ~on_f : (run & ~link_ok);
   assign rr_hit  = rr_cond & (rr_cnt_r == 32'(REMOTE_RESET_CYC - 1));

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !rr_cond) begin
         rr_cnt_r <= esac_pkg::RR_ZERO;
      end else if (rr_cnt_r != 32'(REMOTE_RESET_CYC - 1)) begin
         rr_cnt_r <= rr_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (hold_rst) begin
         ctrl_oe_r  <= 1'b0;
         ctrl_fwd_r <= 1'b0;
         ctrl_o_r   <= 1'b0;
      end else begin
         ctrl_o_r <= ctrl_sel_val;
         if (rr_hit && remote_f) begin
            ctrl_oe_r <= 1'b0;
         end else if (run && remote_f && link_ok) begin
            ctrl_oe_r <= 1'b1;
         end
         if (link_up_r) begin
            ctrl_fwd_r <= ctrl_f;
         end
      end
   end

   assign ctrl_fwd_out       = ctrl_fwd_r;
   assign ctrl_fwd_valid_out = link_up_r & local_mode;
   assign ctrl_o_out         = ctrl_o_r;
   assign ctrl_oe_out        = ctrl_oe_r & remote_f;
   assign remote_reset_out   = rr_hit & local_mode;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_off_quiet;
      @(posedge clk_in) disable iff (sys_rst_in)
      !on_f |=> !rdy_oe_out && !link_oe_out && !alert_oe_out && !ctrl_oe_out && transceiver_lp_out;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("Drivers active while off");

   property p_tri_phase;
      @(posedge clk_in) disable iff (hold_rst)
      (state_r == esac_pkg::ESAC_TRI) |-> !rdy_oe_out && !link_oe_out && !alert_oe_out && !ctrl_oe_out;
   endproperty
   a_tri_phase: assert property (p_tri_phase) else $error("Output driven during tristate phase");

   property p_link_needs;
      @(posedge clk_in) disable iff (hold_rst)
      $rose(link_oe_out) |-> $past(link_ok) && $past(run);
   endproperty
   a_link_needs: assert property (p_link_needs) else $error("Link-up without link");

   property p_no_link_startup;
      @(posedge clk_in) disable iff (sys_rst_in)
      !run |=> !link_oe_out;
   endproperty
   a_no_link_startup: assert property (p_no_link_startup) else $error("Link-up during startup");

   property p_rate_mismatch;
      @(posedge clk_in) disable iff (hold_rst)
      (peer_rate_in != {rs2_f, rs1_f}) |=> !link_oe_out;
   endproperty
   a_rate_mismatch: assert property (p_rate_mismatch) else $error("Link with rate mismatch");

   property p_stop_ready;
      @(posedge clk_in) disable iff (hold_rst)
      (run && local_mode && stop_seen && !buffer_full_in) ##1 !buffer_full_in |-> rdy_oe_out;
   endproperty
   a_stop_ready: assert property (p_stop_ready) else $error("Ready not low after stop");

   property p_buf_full;
      @(posedge clk_in) disable iff (hold_rst)
      buffer_full_in |-> !rdy_oe_out;
   endproperty
   a_buf_full: assert property (p_buf_full) else $error("Ready low with buffer full");

   property p_alert_and;
      @(posedge clk_in) disable iff (hold_rst)
      (run && local_mode && link_up_r && !remote_alert_n_in) |-> alert_oe_out;
   endproperty
   a_alert_and: assert property (p_alert_and) else $error("Remote alert not mirrored");

   property p_irq_mode;
      @(posedge clk_in) disable iff (hold_rst)
      (run && local_mode && irq_line_mode_in && irq_any && !ara_rel_r) ##1 (irq_line_mode_in && irq_any)
         |-> alert_oe_out;
   endproperty
   a_irq_mode: assert property (p_irq_mode) else $error("Interrupt released in interrupt mode");

   property p_ctrl_remote_reset;
      @(posedge clk_in) disable iff (hold_rst)
      (rr_hit && remote_f) |=> !ctrl_oe_out;
   endproperty
   a_ctrl_remote_reset: assert property (p_ctrl_remote_reset) else $error("Control driven after reset");

   property p_ctrl_fwd;
      @(posedge clk_in) disable iff (hold_rst)
      !link_up_r |=> $stable(ctrl_fwd_r);
   endproperty
   a_ctrl_fwd: assert property (p_ctrl_fwd) else $error("Control forwarded without link");

   c_ready:  cover property (@(posedge clk_in) disable iff (hold_rst) $rose(rdy_oe_out));
   c_link:   cover property (@(posedge clk_in) disable iff (hold_rst) $rose(link_oe_out));
   c_ara:    cover property (@(posedge clk_in) disable iff (hold_rst) $rose(ara_rel_r));
   c_rreset: cover property (@(posedge clk_in) disable iff (sys_rst_in) remote_reset_out);

endmodule

/* design/esac_pkg.sv */
/*
 * Constants and types of the extender status, alert and control block.
 * Assumes a single 50 MHz system clock; all times below are converted to cycles here.
 */
package esac_pkg;

   // ---------------------------------------------------------------
   // Clock and times
   // ---------------------------------------------------------------
   localparam int CLK_MHZ              = 50;
   localparam int STARTUP_TRI_NS       = 2000;
   localparam int STARTUP_INIT_NS      = 10000;
   localparam int READY_IDLE_NS        = 50000;
   localparam int ALERT_SAMPLE_NS      = 1000;
   localparam int REMOTE_RESET_US      = 1000;

   // Least times, rounded up to whole cycles
   localparam int STARTUP_TRI_CYC      = (STARTUP_TRI_NS * CLK_MHZ + 999) / 1000;
   localparam int STARTUP_INIT_CYC     = (STARTUP_INIT_NS * CLK_MHZ + 999) / 1000;
   localparam int READY_IDLE_CYC       = (READY_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int ALERT_SAMPLE_CYC     = (ALERT_SAMPLE_NS * CLK_MHZ + 999) / 1000;
   localparam int REMOTE_RESET_CYC     = REMOTE_RESET_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------
   localparam int CNT_W                = 12;
   localparam int RR_CNT_W             = 32;
   localparam int EVENT_W              = 8;
   localparam logic [CNT_W-1:0]    CNT_ZERO = 12'h000;
   localparam logic [RR_CNT_W-1:0] RR_ZERO  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Startup sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ESAC_OFF  = 4'h1,
      ESAC_TRI  = 4'h2,
      ESAC_INIT = 4'h4,
      ESAC_RUN  = 4'h8
   } esac_state_t;

endpackage

/* sim/esac_far_model.sv */
/*
 * Far-side model: the local bus master (STOP on request) and the remote extender's
 * link view (liveness, peer rate, mirrored alert and control).
 * Assumes one clock shared with the block; bench requests arrive on clk_in.
 */
`timescale 1ns/1ns

module esac_far_model (
   input  wire logic       clk_in,
   input  wire logic       stop_req_in,
   input  wire logic       link_en_in,
   input  wire logic       cable_in,
   input  wire logic [1:0] rate_in,
   input  wire logic       ralert_n_in,
   input  wire logic       rctrl_in,
   output logic            scl_out,
   output logic            sda_out,
   output logic [1:0]      peer_rate_out,
   output logic            link_alive_out,
   output logic            cable_ok_out,
   output logic            remote_alert_n_out,
   output logic            remote_ctrl_out
);
   // ---------------------------------------------------------------
   // Bus master and link
   // ---------------------------------------------------------------
   logic [2:0] stp_r    = 3'h0;
   logic       tog_r    = 1'b0;
   logic       scl_r    = 1'b0;
   logic       sda_r    = 1'b0;
   logic [1:0] prate_r  = 2'h0;
   logic       alive_r  = 1'b0;
   logic       cable_r  = 1'b1;
   logic       ralert_r = 1'b1;
   logic       rctrl_r  = 1'b0;

   assign scl_out            = scl_r;
   assign sda_out            = sda_r;
   assign peer_rate_out      = prate_r;
   assign link_alive_out     = alive_r;
   assign cable_ok_out       = cable_r;
   assign remote_alert_n_out = ralert_r;
   assign remote_ctrl_out    = rctrl_r;

   always @(posedge clk_in) begin
      tog_r    <= ~tog_r;
      prate_r  <= rate_in;
      alive_r  <= link_en_in;
      cable_r  <= cable_in;
      // Dead link carries a changing pattern
      ralert_r <= link_en_in ? ralert_n_in : tog_r;
      rctrl_r  <= link_en_in ? rctrl_in : tog_r;
      // STOP: sda low, scl high, then sda rises
      stp_r    <= ((stop_req_in || stp_r != 3'h0) && stp_r != 3'h5) ? stp_r + 3'h1 : 3'h0;
      if (stop_req_in) begin
         sda_r <= 1'b0;
      end
      if (stp_r == 3'h2) begin
         scl_r <= 1'b1;
      end
      if (stp_r == 3'h5) begin
         sda_r <= 1'b1;
      end
   end
endmodule

/* sim/test_extender_status_alert_control.sv */
/*
 * Self-checking bench of the status, alert and control block, local then remote mode.
 * Assumes the far-side model drives the bus and link inputs; remote reset count set to 20.
 */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH %s exp=%0h got=%0h", nm, exp, got); end end
`define WAIT(c, n, nm) begin #1; for (w = 0; w < n && !(c); w++) begin @(posedge clk_in); #1; end \
   `CHK(nm, 1'b1, (c)) if (!(c)) end_sim(); end

module test_extender_status_alert_control;
   logic       clk_in = 1'b0, sys_rst_in = 1'b1, power_on_in = 1'b1, far_side_sel_in = 1'b0;
   logic       buffer_full_in = 1'b0, irq_line_mode_in = 1'b0, ara_lowest_in = 1'b0;
   logic       alert_pin_in = 1'b1, ctrl_pin_in = 1'b0, ctrl_src_sel_in = 1'b0;
   logic       aux_software_value_in = 1'b1;
   logic [7:0] event_in = 8'h00, notify_en_in = 8'h04;
   logic       stop_req = 1'b0, link_en = 1'b0, ralert_n = 1'b1, rctrl = 1'b0, cable = 1'b1;
   logic [1:0] rate = 2'h0, peer_rate_in;
   logic       scl_in, sda_in, link_alive_in, cable_ok_in, remote_alert_n_in, remote_ctrl_in;
   logic       functional_out, transceiver_lp_out, rdy_oe_out, link_oe_out, local_ctl_only_out;
   logic       alert_oe_out, alert_sample_out, ctrl_fwd_out, ctrl_fwd_valid_out, ctrl_o_out;
   logic       ctrl_oe_out, remote_reset_out;
   logic       rdy_o_out, link_o_out, alert_o_out;
   int         n_errors = 0, checks = 0, w;

   always #10 clk_in = ~clk_in;

   esac_far_model far_u (.clk_in(clk_in), .stop_req_in(stop_req), .link_en_in(link_en), .rate_in(rate),
      .cable_in(cable), .ralert_n_in(ralert_n), .rctrl_in(rctrl), .scl_out(scl_in), .sda_out(sda_in),
      .peer_rate_out(peer_rate_in), .link_alive_out(link_alive_in), .cable_ok_out(cable_ok_in),
      .remote_alert_n_out(remote_alert_n_in), .remote_ctrl_out(remote_ctrl_in));

   esac_top #(.REMOTE_RESET_CYC(20)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .power_on_in(power_on_in), .far_side_sel_in(far_side_sel_in), .scl_in(scl_in), .sda_in(sda_in),
      .rate_select_1_in(1'b1), .rate_select_2_in(1'b0), .peer_rate_in(peer_rate_in),
      .link_alive_in(link_alive_in), .cable_ok_in(cable_ok_in), .buffer_full_in(buffer_full_in),
      .event_in(event_in), .notify_en_in(notify_en_in), .irq_line_mode_in(irq_line_mode_in),
      .ara_lowest_in(ara_lowest_in), .alert_pin_in(alert_pin_in), .remote_alert_n_in(remote_alert_n_in),
      .ctrl_pin_in(ctrl_pin_in), .ctrl_src_sel_in(ctrl_src_sel_in),
      .aux_software_value_in(aux_software_value_in), .remote_ctrl_in(remote_ctrl_in),
      .functional_out(functional_out), .transceiver_lp_out(transceiver_lp_out), .rdy_o_out(rdy_o_out),
      .rdy_oe_out(rdy_oe_out), .link_o_out(link_o_out), .link_oe_out(link_oe_out),
      .local_ctl_only_out(local_ctl_only_out), .alert_o_out(alert_o_out), .alert_oe_out(alert_oe_out),
      .alert_sample_out(alert_sample_out), .ctrl_fwd_out(ctrl_fwd_out),
      .ctrl_fwd_valid_out(ctrl_fwd_valid_out), .ctrl_o_out(ctrl_o_out), .ctrl_oe_out(ctrl_oe_out),
      .remote_reset_out(remote_reset_out));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic end_sim();
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic pulse_stop();
      @(posedge clk_in) stop_req <= 1'b1;
      @(posedge clk_in) stop_req <= 1'b0;
   endtask

   task automatic pulse_ara();
      @(posedge clk_in) ara_lowest_in <= 1'b1;
      @(posedge clk_in) ara_lowest_in <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(4);
      `CHK("lp_rst", 1'b1, transceiver_lp_out)
      `CHK("oe_rst", 3'h0, {rdy_oe_out, link_oe_out, alert_oe_out})
      @(posedge clk_in) sys_rst_in <= 1'b0;
      cyc(50);
      `CHK("tri", 5'h00, {functional_out, rdy_oe_out, link_oe_out, alert_oe_out, ctrl_oe_out})
      `WAIT(functional_out === 1'b1, 700, "run")
      cyc(20);
      `CHK("rdy_busy", 1'b0, rdy_oe_out)
      `CHK("link_start", 1'b0, link_oe_out)
      pulse_stop();
      `WAIT(rdy_oe_out === 1'b1, 20, "rdy_stop")
      `CHK("loc_only", 1'b1, local_ctl_only_out)
      @(posedge clk_in) buffer_full_in <= 1'b1;
      cyc(1);
      `CHK("rdy_full", 1'b0, rdy_oe_out)
      @(posedge clk_in) buffer_full_in <= 1'b0;
      rate <= 2'h2;
      link_en <= 1'b1;
      cyc(10);
      `CHK("bad_rate", 1'b0, link_oe_out)
      @(posedge clk_in) rate <= 2'h1;
      cable <= 1'b0;
      cyc(10);
      `CHK("bad_cable", 1'b0, link_oe_out)
      @(posedge clk_in) cable <= 1'b1;
      `WAIT(link_oe_out === 1'b1, 10, "link_up")
      `CHK("rdy_link", 1'b1, rdy_oe_out)
      `CHK("not_loc", 1'b0, local_ctl_only_out)
      `CHK("od_data", 3'h0, {rdy_o_out, link_o_out, alert_o_out})
      @(posedge clk_in) event_in <= 8'h80;
      cyc(3);
      `CHK("no_en", 1'b0, alert_oe_out)
      @(posedge clk_in) event_in <= 8'h84;
      `WAIT(alert_oe_out === 1'b1, 5, "evt")
      pulse_ara();
      `WAIT(alert_oe_out === 1'b0, 5, "ara")
      @(posedge clk_in) ralert_n <= 1'b0;
      `WAIT(alert_oe_out === 1'b1, 5, "remote")
      @(posedge clk_in) ralert_n <= 1'b1;
      notify_en_in <= 8'h00;
      `WAIT(alert_oe_out === 1'b0, 5, "clr_en")
      @(posedge clk_in) notify_en_in <= 8'h04;
      irq_line_mode_in <= 1'b1;
      `WAIT(alert_oe_out === 1'b1, 5, "evt2")
      pulse_ara();
      cyc(5);
      `CHK("irq_mode", 1'b1, alert_oe_out)
      @(posedge clk_in) event_in <= 8'h80;
      `WAIT(alert_oe_out === 1'b0, 5, "clr_evt")
      @(posedge clk_in) ctrl_pin_in <= 1'b1;
      `WAIT(ctrl_fwd_out === 1'b1, 10, "fwd")
      `CHK("fwd_v", 1'b1, ctrl_fwd_valid_out)
      @(posedge clk_in) link_en <= 1'b0;
      `WAIT(link_oe_out === 1'b0, 5, "link_dn")
      @(posedge clk_in) ctrl_pin_in <= 1'b0;
      cyc(8);
      `CHK("fwd_hold", 2'h2, {ctrl_fwd_out, ctrl_fwd_valid_out})
      @(posedge clk_in) power_on_in <= 1'b0;
      `WAIT(transceiver_lp_out === 1'b1, 10, "lp_off")
      `CHK("off", 4'h0, {functional_out, rdy_oe_out, link_oe_out, alert_oe_out})
      cyc(10);
      `CHK("rr_early", 1'b0, remote_reset_out)
      `WAIT(remote_reset_out === 1'b1, 30, "rr")
      @(posedge clk_in) power_on_in <= 1'b1;
      `WAIT(functional_out === 1'b1, 700, "run_on")
      cyc(1800);
      `CHK("rdy_early", 1'b0, rdy_oe_out)
      `WAIT(rdy_oe_out === 1'b1, 200, "rdy_idle")
      @(posedge clk_in) sys_rst_in <= 1'b1;
      power_on_in <= 1'b1;
      far_side_sel_in <= 1'b1;
      cyc(5);
      @(posedge clk_in) sys_rst_in <= 1'b0;
      `WAIT(functional_out === 1'b1, 700, "run_rm")
      pulse_stop();
      cyc(20);
      `CHK("rdy_rm", 1'b0, rdy_oe_out)
      `CHK("ctl_oe0", 1'b0, ctrl_oe_out)
      @(posedge clk_in) link_en <= 1'b1;
      rctrl <= 1'b1;
      event_in <= 8'h04;
      `WAIT(ctrl_oe_out === 1'b1, 10, "ctl_oe1")
      `WAIT(link_oe_out === 1'b1, 10, "link_rm")
      `CHK("ctl_pin", 1'b1, ctrl_o_out)
      `CHK("alert_rm", 1'b0, alert_oe_out)
      @(posedge clk_in) ctrl_src_sel_in <= 1'b1;
      aux_software_value_in <= 1'b0;
      cyc(2);
      `CHK("ctl_sw", 1'b0, ctrl_o_out)
      @(posedge clk_in) alert_pin_in <= 1'b0;
      `WAIT(alert_sample_out === 1'b0, 70, "sample")
      @(posedge clk_in) link_en <= 1'b0;
      cyc(10);
      `CHK("ctl_hold", 1'b1, ctrl_oe_out)
      `WAIT(ctrl_oe_out === 1'b0, 40, "ctl_rr")
      end_sim();
   end
endmodule
